// ---- design/saf_pkg.sv ----
// Package: shared constants and types for the step-adaptive filter and calibration block
package saf_pkg;
	// ==========================================================
	// Data widths
	localparam int SAMPLE_W  = 24;
	localparam int COEF_W    = 24;
	localparam int ACC_W     = 33;
	localparam int FIR_TAPS  = 22;
	// ==========================================================
	// Step detection: threshold is 1% of full scale
	localparam int STEP_PCT  = 1;
	localparam logic [SAMPLE_W-1:0] STEP_THRESH = SAMPLE_W'((64'(1) << SAMPLE_W) * STEP_PCT / 100);
	// ==========================================================
	// Averaging schedule while the step settles
	localparam int AVG_INIT_CHOP   = 2;
	localparam int AVG_INIT_NOCHOP = 1;
	localparam logic [4:0] RUN2  = 5'h02;
	localparam logic [4:0] RUN4  = 5'h04;
	localparam logic [4:0] RUN8  = 5'h08;
	localparam logic [4:0] RUN16 = 5'h06;
	// ==========================================================
	// Calibration durations in output periods
	localparam logic [6:0] ZS_OUT_CHOP   = 7'h16;
	localparam logic [6:0] ZS_OUT_NOCHOP = 7'h18;
	localparam logic [6:0] FS_OUT_CHOP   = 7'h2c;
	localparam logic [6:0] FS_OUT_NOCHOP = 7'h30;
	// ==========================================================
	// Mode-select codes
	localparam logic [2:0] MODE_IDLE   = 3'h0;
	localparam logic [2:0] MODE_CONT   = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_IZS    = 3'h4;
	localparam logic [2:0] MODE_IFS    = 3'h5;
	localparam logic [2:0] MODE_SZS    = 3'h6;
	localparam logic [2:0] MODE_SFS    = 3'h7;
	// ==========================================================
	// Gain normalisation: unity gain coefficient
	localparam logic [COEF_W-1:0] GAIN_UNITY = 24'h800000;
	localparam logic [COEF_W-1:0] OFFS_RST   = 24'h000000;
	localparam int GAIN_SHIFT = 23;
	// ==========================================================
	// Host command codes on the link
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0, CMD_MODE = 3'h1, CMD_FILT = 3'h2,
		CMD_WOFS = 3'h3, CMD_WGAIN = 3'h4, CMD_ROFS = 3'h5, CMD_RGAIN = 3'h6
	} saf_cmd_t;
	// Second-stage operating state
	typedef enum logic [2:0] {
		ST_FIR = 3'b001, ST_HOLD = 3'b010, ST_RAMP = 3'b100
	} saf_stage_t;
	// ==========================================================
	// APB register offsets of the host controller
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_FILT   = 8'h04;
	localparam logic [7:0] A_COEF   = 8'h08;
	localparam logic [7:0] A_CMD    = 8'h0c;
	localparam logic [7:0] A_STAT   = 8'h10;
	localparam logic [7:0] A_RDATA  = 8'h14;
	localparam logic [7:0] A_RESULT = 8'h18;
	localparam int FLT_CHOP = 0;
	localparam int FLT_STEP = 1;
	localparam int FLT_BYP  = 2;
	localparam int FLT_RES24 = 3;
endpackage : saf_pkg

// ---- design/saf_link_if.sv ----
// Interface: link between host controller and filter/calibration device
`timescale 1ns/1ps
interface saf_link_if;
	import saf_pkg::*;
	saf_cmd_t              cmd;
	logic                  cmdValid;
	logic                  chan;
	logic [COEF_W-1:0]     wdata;
	logic [2:0]            modeSel;
	logic [3:0]            filtBits;
	logic                  rdValid;
	logic [COEF_W-1:0]     rdata;
	logic                  outValid;
	logic [SAMPLE_W-1:0]   outData;
	logic                  readyN;
	logic                  settlingFlag;
	logic [2:0]            modeNow;
	modport dev  (input cmd, cmdValid, chan, wdata, modeSel, filtBits,
	              output rdValid, rdata, outValid, outData, readyN, settlingFlag, modeNow);
	modport host (output cmd, cmdValid, chan, wdata, modeSel, filtBits,
	              input rdValid, rdata, outValid, outData, readyN, settlingFlag, modeNow);
endinterface : saf_link_if

// ---- design/saf_device.sv ----
// Device end: second-stage filter, step handling, bypass and calibration coefficients
// How it works
// - Step enable bit selects adaptive step handling
// - Compare with sample two back, 1% threshold
// - Settling flag set on step, cleared at FIR
// - Hold average 2 chop, 1 nonchop
// - Ramp 2x2, 4x4, 8x8, 6x16 then FIR
// - Chop adaptive settles after two outputs
// - Bypass bit passes first-stage output directly
// - Host pairs bypass outputs when chopping
// - Mode write accepted at any time
// - Coefficients are 24 bits, readable and writable
// - Subtract offset, then multiply by gain
// - Zero-scale to offset, full-scale to gain; internal full-scale also to offset
// - 33-bit arithmetic, 16 or 24 bit result
// - Host follows internal full-scale with zero-scale; saf_host does not, software must issue it over APB
// - Host does zero-scale before system full-scale; saf_host does not enforce this order, software must
// - Coefficients valid at every output rate
// - Chop bit selects chop or nonchop
// - Code 100 starts internal zero-scale
// - Calibration length 22/24 zero-scale, 44/48 full-scale, then idle, ready low
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module saf_device import saf_pkg::*; #(
	parameter int NCHAN = 2
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 rawValid,
	input  wire logic [SAMPLE_W-1:0]  rawData,
	saf_link_if.dev                   lnk
);
	// ==========================================================
	// Registers
	logic [2:0]            modeFF;
	logic [3:0]            filtFF;
	logic [COEF_W-1:0]     offsFF [NCHAN];
	logic [COEF_W-1:0]     gainFF [NCHAN];
	logic                  chanFF;
	logic [SAMPLE_W-1:0]   hist   [15];
	logic [SAMPLE_W-1:0]   firTaps [FIR_TAPS-1];
	saf_stage_t            stageFF;
	logic [4:0]            avgLenFF;
	logic [4:0]            runCntFF;
	logic [6:0]            calCntFF;
	logic                  fsPhaseFF;
	logic                  rdyNFF, settleFF, oValidFF, rdValidFF;
	logic [SAMPLE_W-1:0]   oDataFF;
	logic [COEF_W-1:0]     rdataFF;
	saf_stage_t            nxtStage;
	logic [4:0]            nxtAvgLen, nxtRun;
	wire chop    = filtFF[FLT_CHOP];
	wire stepEn  = filtFF[FLT_STEP] && !filtFF[FLT_BYP];
	wire calib   = modeFF[2];
	// ==========================================================
	// Step detection against the sample two back
	logic signed [SAMPLE_W:0] diff;
	logic [SAMPLE_W:0]        adiff;
	always_comb begin
		diff  = $signed({1'b0, rawData}) - $signed({1'b0, hist[1]});
		adiff = diff[SAMPLE_W] ? (SAMPLE_W+1)'(-diff) : diff;
	end
	wire stepHit = stepEn && (adiff > {1'b0, STEP_THRESH});
	// ==========================================================
	// History and FIR / moving average sums
	logic [ACC_W-1:0] firSum, avgSum;
	always_comb begin
		firSum = ACC_W'(rawData);
		for (int i = 0; i < FIR_TAPS - 1; i++) begin
			firSum = firSum + ACC_W'(firTaps[i]);
		end
		avgSum = ACC_W'(rawData);
		for (int i = 0; i < 15; i++) begin
			if (5'(i + 1) < nxtAvgLen) begin
				avgSum = avgSum + ACC_W'(hist[i]);
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < 15; i++) hist[i] <= '0;
			for (int i = 0; i < FIR_TAPS - 1; i++) firTaps[i] <= '0;
		end else if (rawValid) begin
			hist[0] <= rawData;
			firTaps[0] <= rawData;
			for (int i = 1; i < 15; i++) hist[i] <= hist[i-1];
			for (int i = 1; i < FIR_TAPS - 1; i++) firTaps[i] <= firTaps[i-1];
		end
	end
	// ==========================================================
	// Second-stage state machine
	always_comb begin
		nxtStage  = stageFF;
		nxtAvgLen = avgLenFF;
		nxtRun    = runCntFF;
		if (!stepEn) begin
			nxtStage = ST_FIR;
		end else if (stepHit) begin
			nxtStage  = ST_HOLD;
			nxtAvgLen = chop ? 5'(AVG_INIT_CHOP) : 5'(AVG_INIT_NOCHOP);
		end else begin
			unique case (stageFF)
				ST_FIR: begin
					nxtStage = ST_FIR;
				end
				ST_HOLD: begin
					nxtStage  = ST_RAMP;
					nxtAvgLen = 5'h02;
					nxtRun    = RUN2 - 5'h01;
				end
				ST_RAMP: begin
					if (runCntFF != 5'h00) begin
						nxtRun = runCntFF - 5'h01;
					end else if (avgLenFF == 5'h10) begin
						nxtStage = ST_FIR;
					end else begin
						nxtAvgLen = {avgLenFF[3:0], 1'b0};
						nxtRun = ((avgLenFF == 5'h08) ? RUN16 : {avgLenFF[3:0], 1'b0}) - 5'h01;
					end
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stageFF  <= ST_FIR;
			avgLenFF <= 5'h01;
			runCntFF <= 5'h00;
		end else if (rawValid) begin
			stageFF  <= nxtStage;
			avgLenFF <= nxtAvgLen;
			runCntFF <= nxtRun;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) settleFF <= 1'b0;
		else if (!stepEn) settleFF <= 1'b0;
		else if (rawValid && stepHit) settleFF <= 1'b1;
		else if (rawValid && nxtStage == ST_FIR) settleFF <= 1'b0;
	end
	// ==========================================================
	// Filter output select and calibration correction
	logic [SAMPLE_W-1:0] filtOut;
	logic signed [ACC_W-1:0] corr;
	logic signed [ACC_W+COEF_W:0] prod;
	logic [SAMPLE_W-1:0] finalOut;
	always_comb begin
		if (filtFF[FLT_BYP]) filtOut = rawData;
		// A sample is filtered in the stage it moves the filter into
		else if (nxtStage == ST_FIR) filtOut = SAMPLE_W'(firSum / ACC_W'(FIR_TAPS));
		else filtOut = SAMPLE_W'(avgSum / ACC_W'(nxtAvgLen));
		corr = $signed(ACC_W'(filtOut)) - $signed(ACC_W'(offsFF[chanFF]));
		prod = (ACC_W+COEF_W+1)'(corr * $signed({1'b0, gainFF[chanFF]}));
		prod = prod >>> GAIN_SHIFT;
		if (prod < 0) finalOut = '0;
		else if (prod > (ACC_W+COEF_W+1)'({SAMPLE_W{1'b1}})) finalOut = '1;
		else finalOut = prod[SAMPLE_W-1:0];
		if (!filtFF[FLT_RES24]) finalOut[7:0] = 8'h00;
	end
	// ==========================================================
	// Mode and calibration sequencing
	wire [6:0] calLen = (modeFF == MODE_IFS || modeFF == MODE_SFS)
		? (chop ? FS_OUT_CHOP : FS_OUT_NOCHOP) : (chop ? ZS_OUT_CHOP : ZS_OUT_NOCHOP);
	wire calDone = calib && rawValid && (calCntFF == calLen - 7'h01);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			modeFF   <= MODE_IDLE;
			calCntFF <= 7'h00;
		end else if (lnk.cmdValid && lnk.cmd == CMD_MODE) begin
			modeFF   <= lnk.modeSel;
			calCntFF <= 7'h00;
		end else if (calDone) begin
			modeFF   <= MODE_IDLE;
			calCntFF <= 7'h00;
		end else if (calib && rawValid) begin
			calCntFF <= calCntFF + 7'h01;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			filtFF <= 4'h9;
			chanFF <= 1'b0;
		end else if (lnk.cmdValid) begin
			if (lnk.cmd == CMD_FILT) filtFF <= lnk.filtBits;
			if (lnk.cmd == CMD_MODE) chanFF <= lnk.chan;
		end
	end
	// Coefficient store; host writes and calibration results share one port
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int c = 0; c < NCHAN; c++) begin
				offsFF[c] <= OFFS_RST;
				gainFF[c] <= GAIN_UNITY;
			end
		end else if (lnk.cmdValid && lnk.cmd == CMD_WOFS) begin
			offsFF[lnk.chan] <= lnk.wdata;
		end else if (lnk.cmdValid && lnk.cmd == CMD_WGAIN) begin
			gainFF[lnk.chan] <= lnk.wdata;
		end else if (calDone) begin
			if (modeFF == MODE_IZS || modeFF == MODE_SZS || modeFF == MODE_IFS)
				offsFF[chanFF] <= filtOut;
			if (modeFF == MODE_IFS || modeFF == MODE_SFS)
				gainFF[chanFF] <= filtOut;
		end
	end
	// ==========================================================
	// Link outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdValidFF <= 1'b0;
			rdataFF   <= '0;
		end else begin
			rdValidFF <= lnk.cmdValid && (lnk.cmd == CMD_ROFS || lnk.cmd == CMD_RGAIN);
			if (lnk.cmdValid && lnk.cmd == CMD_ROFS) rdataFF <= offsFF[lnk.chan];
			if (lnk.cmdValid && lnk.cmd == CMD_RGAIN) rdataFF <= gainFF[lnk.chan];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			oValidFF <= 1'b0;
			oDataFF  <= '0;
			rdyNFF   <= 1'b1;
		end else begin
			oValidFF <= rawValid && (modeFF == MODE_CONT || modeFF == MODE_SINGLE);
			if (rawValid && !calib) oDataFF <= finalOut;
			if (lnk.cmdValid && lnk.cmd == CMD_MODE) rdyNFF <= 1'b1;
			else if (calDone) rdyNFF <= 1'b0;
			else if (rawValid && (modeFF == MODE_CONT || modeFF == MODE_SINGLE)) rdyNFF <= 1'b0;
		end
	end
	assign lnk.rdValid      = rdValidFF;
	assign lnk.rdata        = rdataFF;
	assign lnk.outValid     = oValidFF;
	assign lnk.outData      = oDataFF;
	assign lnk.readyN       = rdyNFF;
	assign lnk.settlingFlag = settleFF;
	assign lnk.modeNow      = modeFF;
endmodule : saf_device

// ---- design/saf_host.sv ----
// Host end: APB registers that issue commands and collect device results
`timescale 1ns/1ps
module saf_host import saf_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	saf_link_if.host         lnk
);
	logic [3:0]  ctrlFF;
	logic [3:0]  filtFF;
	logic [23:0] coefFF;
	saf_cmd_t    cmdFF;
	logic        cmdVFF, chanFF, pairFF;
	logic [23:0] rdataFF, resFF, resPrevFF;
	logic [31:0] prdataFF;
	logic        preadyFF, perrFF;
	wire acc = psel && penable && !preadyFF;
	wire wr  = acc && pwrite;
	wire mapped = paddr inside {A_CTRL, A_FILT, A_COEF, A_CMD, A_STAT, A_RDATA, A_RESULT};
	// ==========================================================
	// APB slave, one wait state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrlFF <= 4'h0; filtFF <= 4'h9; coefFF <= '0;
			cmdFF <= CMD_NONE; cmdVFF <= 1'b0; chanFF <= 1'b0;
			preadyFF <= 1'b0; perrFF <= 1'b0; prdataFF <= '0;
		end else begin
			cmdVFF   <= 1'b0;
			preadyFF <= acc;
			perrFF   <= acc && !mapped;
			if (wr && paddr == A_CTRL) ctrlFF <= pwdata[3:0];
			if (wr && paddr == A_FILT) filtFF <= pwdata[3:0];
			if (wr && paddr == A_COEF) coefFF <= pwdata[23:0];
			if (wr && paddr == A_CMD) begin
				cmdFF  <= saf_cmd_t'(pwdata[2:0]);
				chanFF <= ctrlFF[3];
				cmdVFF <= pwdata[2:0] != 3'h0 && pwdata[2:0] != 3'h7;
			end
			if (acc && !pwrite) begin
				unique case (paddr)
					A_CTRL:   prdataFF <= {28'h0, ctrlFF};
					A_FILT:   prdataFF <= {28'h0, filtFF};
					A_COEF:   prdataFF <= {8'h0, coefFF};
					A_STAT:   prdataFF <= {26'h0, pairFF, lnk.modeNow, lnk.settlingFlag, lnk.readyN};
					A_RDATA:  prdataFF <= {8'h0, rdataFF};
					A_RESULT: prdataFF <= {8'h0, resFF};
					default:  prdataFF <= 32'h0;
				endcase
			end
		end
	end
	// ==========================================================
	// Device answers; in bypass with chop, results are paired
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdataFF <= '0; resFF <= '0; resPrevFF <= '0; pairFF <= 1'b0;
		end else begin
			if (lnk.rdValid) rdataFF <= lnk.rdata;
			if (lnk.cmdValid && lnk.cmd == CMD_FILT) pairFF <= 1'b0;
			else if (lnk.outValid) begin
				if (filtFF[FLT_BYP] && filtFF[FLT_CHOP]) begin
					pairFF <= !pairFF;
					resPrevFF <= lnk.outData;
					if (pairFF)
						resFF <= 24'(({1'b0, resPrevFF} + {1'b0, lnk.outData}) >> 1);
				end else begin
					resFF <= lnk.outData;
				end
			end
		end
	end
	assign lnk.cmd      = cmdFF;
	assign lnk.cmdValid = cmdVFF;
	assign lnk.chan     = chanFF;
	assign lnk.wdata    = coefFF;
	assign lnk.modeSel  = ctrlFF[2:0];
	assign lnk.filtBits = filtFF;
	assign prdata  = prdataFF;
	assign pready  = preadyFF;
	assign pslverr = perrFF;
endmodule : saf_host

// ---- tb/saf_link_monitor.sv ----
// Checker: link properties between the host and device ends
`timescale 1ns/1ps
module saf_link_monitor import saf_pkg::*; (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire saf_cmd_t    cmd,
	input wire logic        cmdValid,
	input wire logic [2:0]  modeSel,
	input wire logic [3:0]  filtBits,
	input wire logic        rdValid,
	input wire logic        outValid,
	input wire logic        readyN,
	input wire logic        settlingFlag,
	input wire logic [2:0]  modeNow
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Request shapes
	sequence rdReq;
		cmdValid && (cmd == CMD_ROFS || cmd == CMD_RGAIN);
	endsequence
	sequence modeReq;
		cmdValid && cmd == CMD_MODE;
	endsequence
	sequence calReq;
		cmdValid && cmd == CMD_MODE && modeSel[2];
	endsequence
	// ==========================================================
	// Properties
	chk_read_answer: assert property (rdReq |=> rdValid) else $error("coefficient read not answered");
	chk_read_cause: assert property (rdValid |-> $past(cmdValid && (cmd == CMD_ROFS || cmd == CMD_RGAIN)))
		else $error("read answer without request");
	chk_mode_taken: assert property (modeReq |=> modeNow == $past(modeSel)) else $error("mode write ignored");
	chk_cal_busy: assert property (calReq |=> readyN && modeNow[2]) else $error("calibration not busy");
	chk_cal_stays: assert property (calReq ##1 (!cmdValid) [*4] |-> readyN && modeNow[2])
		else $error("calibration ended too soon");
	chk_cal_end: assert property ($fell(readyN) && $past(modeNow[2]) |-> modeNow == MODE_IDLE)
		else $error("mode not idle after calibration");
	chk_out_conv: assert property (outValid |-> modeNow == MODE_CONT || modeNow == MODE_SINGLE)
		else $error("output outside conversion");
	chk_step_off: assert property (!filtBits[FLT_STEP] |-> !$rose(settlingFlag))
		else $error("settling flag with step handling off");
	chk_bypass_calm: assert property (filtBits[FLT_BYP] |-> !$rose(settlingFlag))
		else $error("settling flag in bypass");
endmodule : saf_link_monitor

// ---- tb/saf_tb.sv ----
// Testbench: host and device joined by the link, driven over APB
`timescale 1ns/1ps
module saf_tb import saf_pkg::*;;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rawValid = 1'b0;
	logic [23:0] rawData = 24'h0;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cyc = 0;
	saf_link_if lnk();
	saf_device saf_device_i (.ref_clk(ref_clk), .rst(rst), .rawValid(rawValid), .rawData(rawData), .lnk(lnk));
	saf_host saf_host_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
	saf_link_monitor saf_link_monitor_i (.ref_clk(ref_clk), .rst(rst), .cmd(lnk.cmd), .cmdValid(lnk.cmdValid),
		.modeSel(lnk.modeSel), .filtBits(lnk.filtBits), .rdValid(lnk.rdValid), .outValid(lnk.outValid),
		.readyN(lnk.readyN), .settlingFlag(lnk.settlingFlag), .modeNow(lnk.modeNow));
	// ==========================================================
	// Clock and timeout
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// ==========================================================
	// Tasks
	task automatic results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string nm);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(nm, exp, q & m);
	endtask : rd
	task automatic cmd(input saf_cmd_t c);
		wr(A_CMD, {29'h0, c});
	endtask : cmd
	task automatic mode(input logic ch, input logic [2:0] m);
		wr(A_CTRL, {28'h0, ch, m});
		cmd(CMD_MODE);
	endtask : mode
	task automatic filt(input logic [3:0] v);
		wr(A_FILT, {28'h0, v});
		cmd(CMD_FILT);
	endtask : filt
	task automatic putc(input logic ch, input saf_cmd_t c, input logic [23:0] v);
		wr(A_CTRL, {28'h0, ch, 3'h0});
		wr(A_COEF, {8'h0, v});
		cmd(c);
	endtask : putc
	task automatic getc(input logic ch, input saf_cmd_t c, input logic [23:0] v, input string nm);
		wr(A_CTRL, {28'h0, ch, 3'h0});
		cmd(c);
		rd(A_RDATA, {8'h0, v}, 32'hffffff, nm);
	endtask : getc
	task automatic samp(input logic [23:0] v, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			rawValid <= 1'b1;
			rawData <= v;
			@(posedge ref_clk);
			rawValid <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
	endtask : samp
	// ==========================================================
	// Main sequence
	initial begin
		logic [23:0] v;
		logic [31:0] q;
		logic        e;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(A_FILT, 32'h9, 32'hf, "filter reset");
		rd(A_STAT, 32'h1, 32'h1f, "status reset");
		getc(1'b0, CMD_ROFS, OFFS_RST, "offset reset");
		getc(1'b1, CMD_RGAIN, GAIN_UNITY, "gain reset");
		apb(1'b0, 8'h1c, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		mode(1'b0, MODE_CONT);
		filt(4'hb);
		samp(24'h010000, 30);
		rd(A_STAT, 32'h4, 32'h1f, "steady flag");
		rd(A_RESULT, 32'h010000, 32'hffffff, "fir result");
		samp(24'h400000, 1);
		rd(A_RESULT, 32'h208000, 32'hffffff, "step first");
		samp(24'h400000, 1);
		rd(A_STAT, 32'h6, 32'h1f, "step flag");
		rd(A_RESULT, 32'h400000, 32'hffffff, "step result");
		samp(24'h400000, 20);
		rd(A_STAT, 32'h6, 32'h1f, "ramp flag");
		samp(24'h400000, 1);
		rd(A_STAT, 32'h4, 32'h1f, "flag back");
		samp(24'h400000, 9);
		rd(A_RESULT, 32'h400000, 32'hffffff, "settled result");
		filt(4'h9);
		samp(24'h010000, 2);
		rd(A_STAT, 32'h4, 32'h1f, "step off flag");
		filt(4'ha);
		samp(24'h400000, 1);
		rd(A_RESULT, 32'h400000, 32'hffffff, "nonchop step");
		rd(A_STAT, 32'h6, 32'h1f, "nonchop flag");
		filt(4'he);
		for (int i = 0; i < 3; i++) begin
			samp(24'h100000, 1);
			samp(24'h500000, 1);
		end
		rd(A_STAT, 32'h4, 32'h1f, "bypass flag");
		rd(A_RESULT, 32'h500000, 32'hffffff, "bypass result");
		filt(4'hd);
		for (int i = 0; i < 3; i++) begin
			samp(24'h100000, 1);
			samp(24'h500000, 1);
		end
		rd(A_RESULT, 32'h300000, 32'hffffff, "pair result");
		putc(1'b0, CMD_WOFS, 24'h001000);
		putc(1'b0, CMD_WGAIN, 24'h400000);
		getc(1'b0, CMD_ROFS, 24'h001000, "offset back");
		getc(1'b0, CMD_RGAIN, 24'h400000, "gain back");
		filt(4'hc);
		samp(24'h201000, 1);
		rd(A_RESULT, 32'h100000, 32'hffffff, "scaled result");
		filt(4'h4);
		samp(24'h201234, 1);
		rd(A_RESULT, 32'h100100, 32'hffffff, "short result");
		filt(4'h9);
		for (int i = 0; i < 4; i++) begin
			v = 24'h300000 + 24'(i) * 24'h010000;
			mode(1'b0, MODE_IZS + 3'(i));
			rd(A_STAT, {27'h0, 3'(4 + i), 2'b01}, 32'h1f, "cal busy");
			samp(v, i[0] ? 43 : 21);
			rd(A_STAT, {27'h0, 3'(4 + i), 2'b01}, 32'h1f, "cal still busy");
			samp(v, 1);
			rd(A_STAT, 32'h0, 32'h1f, "cal done");
			getc(1'b0, i[0] ? CMD_RGAIN : CMD_ROFS, v, "cal coef");
		end
		filt(4'h8);
		v = 24'h0a0000;
		mode(1'b1, MODE_IZS);
		samp(v, 10);
		mode(1'b1, MODE_IZS);
		samp(v, 23);
		rd(A_STAT, 32'h11, 32'h1f, "restart busy");
		samp(v, 1);
		rd(A_STAT, 32'h0, 32'h1f, "nonchop done");
		getc(1'b1, CMD_ROFS, v, "chan offset");
		results();
	end
endmodule : saf_tb
